// ===== src/spt_top.sv
// Synchronous serial port: SPI transfer engine and I2C start sequencer
// Summary of operation
// - Shift data most significant bit first
// - After eight bits, buffer loaded, flags set
// - Next byte may arrive before buffer read
// - Write during transfer dropped, collision flag set
// - Collision flag stays until software clears
// - Reading the buffer clears buffer-full flag
// - Shift register reached only through buffer
// - Enable assigns pins; disable aborts transfer and start, keeps flags and buffer
// - Config selects role, polarity, phase, edge, rate
// - Shift out one edge, sample the other
// - Master drives clock; slave only follows it
// - Pin directions follow role automatically
// - Start enable with lines high loads generator
// - Timeout with lines high pulls SDA low
// - Second timeout clears start, holds SDA low
// - Low lines or early SCL low abort start
// - Buffer write during start flags collision
// - Control two writes blocked during start
`timescale 1ns/1ps
`default_nettype none

module spt_top
   import spt_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire spt_cfg_s CFG,
   input wire logic BUF_WR,
   input wire logic [7:0] BUF_WDATA,
   input wire logic BUF_RD,
   output logic [7:0] BUF_RDATA,
   input wire logic IRQ_CLR,
   input wire logic WRITE_COLLISION_FLAG_CLR,
   input wire logic BCOL_CLR,
   input wire logic CTL2_WR,
   input wire logic [SPT_CTL2_W-1:0] CTL2_WDATA,
   output logic [SPT_CTL2_W-1:0] CTL2_Q,
   input wire logic [SPT_RLD_W-1:0] RATE_RELOAD,
   output spt_status_s STATUS,
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic SERIAL_DATA_IN,
   output logic SDO_O,
   output logic SDO_OE,
   input wire logic SS_B,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic SCL_I
);

   spt_state_s s_reg;
   spt_state_s s_next;

   logic sda_s;
   logic scl_s;
   logic sdi_s;
   logic ss_off;
   logic spi_on;
   logic i2c_on;
   logic i2c_busy;
   logic xfer_busy;
   logic m_run;
   logic m_lead;
   logic m_samp;
   logic m_done;
   logic s_edge;
   logic s_samp;
   logic s_done;
   logic complete;
   logic wr_hit;
   logic wr_coll;
   logic wr_go;
   logic i2c_start;
   logic rg_load;
   logic rg_run;
   logic rg_tick;
   logic [SPT_RLD_W-1:0] rate_val;
   logic [SPT_RLD_W-1:0] rg_val;

   // Only second stages of the synchronisers are read
   assign sda_s = s_reg.sda_sy[1];
   assign scl_s = s_reg.scl_sy[1];
   assign sdi_s = s_reg.sdi_sy[1];
   assign ss_off = CFG.ss_en & s_reg.ss_sy[1];

   assign spi_on = CFG.enable & ~CFG.i2c_mode;
   assign i2c_on = CFG.enable & CFG.i2c_mode;
   assign i2c_busy = (s_reg.ist == I2C_WAIT1) | (s_reg.ist == I2C_HOLD);
   assign xfer_busy = s_reg.busy | (s_reg.bits != '0) | i2c_busy;

   // Master timing
   assign m_run = s_reg.busy & CFG.master & spi_on;
   assign m_lead = ~s_reg.edges[0];
   assign m_samp = m_lead ~^ CFG.out_on_idle;
   assign m_done = m_run & (s_reg.edges == SPT_EDGE_CNT) & ~s_reg.pend;

   // Slave follows the synchronised clock only
   assign s_edge = s_reg.sck_sy[1] ^ s_reg.sck_prev;
   assign s_samp = (s_reg.sck_sy[1] ^ CFG.clk_pol) ~^ CFG.out_on_idle;
   assign s_done = s_reg.bits == SPT_BIT_CNT;

   assign complete = spi_on & (CFG.master ? m_done : s_done);

   assign wr_hit = BUF_WR & CFG.enable;
   assign wr_coll = wr_hit & xfer_busy;
   assign wr_go = wr_hit & ~xfer_busy & ~CFG.i2c_mode;

   assign i2c_start = i2c_on & (s_reg.ist == I2C_IDLE) & s_reg.ctl2[SPT_SEN_BIT] & sda_s & scl_s;

   // Fixed rates, or the reload value for the last choice (rate_sel 3)
   assign rate_val = (CFG.rate_sel == 2'h0) ? SPT_HALF_RATE0 :
                     (CFG.rate_sel == 2'h1) ? SPT_HALF_RATE1 :
                     (CFG.rate_sel == 2'h2) ? SPT_HALF_RATE2 : RATE_RELOAD;
   assign rg_val = CFG.i2c_mode ? RATE_RELOAD : rate_val;
   assign rg_load = (wr_go & CFG.master) | i2c_start;
   assign rg_run = m_run | (i2c_on & i2c_busy);

   spt_rate_gen #(
      .RLD_W(SPT_RLD_W)
   ) u_rate_gen (
      .clk(CLK),
      .rst_b(RST_B),
      .load(rg_load),
      .run(rg_run),
      .reload(rg_val),
      .tick(rg_tick)
   );

   always_comb begin
      s_next = s_reg;
      s_next.sck_sy = {s_reg.sck_sy[0], SCK_I};
      s_next.sdi_sy = {s_reg.sdi_sy[0], SERIAL_DATA_IN};
      s_next.ss_sy = {s_reg.ss_sy[0], SS_B};
      s_next.sda_sy = {s_reg.sda_sy[0], SDA_I};
      s_next.scl_sy = {s_reg.scl_sy[0], SCL_I};
      s_next.sck_prev = s_reg.sck_sy[1];

      // Disabled port drops any transfer so it can be reconfigured
      if (!spi_on) begin
         s_next.busy = 1'b0;
         s_next.pend = 1'b0;
         s_next.edges = '0;
         s_next.bits = '0;
      end
      if (!s_reg.busy) begin
         s_next.sck = CFG.clk_pol;
      end

      // Master: one generator tick per half period
      if (m_run && rg_tick) begin
         if (s_reg.pend) begin
            s_next.shift = {s_next.shift[6:0], sdi_s};
            s_next.pend = 1'b0;
         end
         if (s_reg.edges != SPT_EDGE_CNT) begin
            s_next.edges = s_reg.edges + SPT_EDGE_STEP;
            s_next.sck = ~s_reg.sck;
            if (m_samp) begin
               // End-of-bit sampling defers the capture by half a period
               if (CFG.sample_end) begin
                  s_next.pend = 1'b1;
               end else begin
                  s_next.shift = {s_next.shift[6:0], sdi_s};
               end
            end else begin
               s_next.serial_data_out = s_next.shift[7];
            end
         end
      end

      // Slave: no shifting without the far clock
      if (spi_on && !CFG.master) begin
         if (ss_off) begin
            s_next.bits = '0;
         end else if (s_edge) begin
            if (s_samp) begin
               s_next.shift = {s_reg.shift[6:0], sdi_s};
               s_next.bits = s_reg.bits + SPT_BIT_STEP;
            end else begin
               s_next.serial_data_out = s_reg.shift[7];
            end
         end
      end

      // Shift register only loads from a buffer write
      if (spi_on && wr_go) begin
         s_next.shift = BUF_WDATA;
         s_next.serial_data_out = BUF_WDATA[7];
         if (CFG.master) begin
            s_next.busy = 1'b1;
            s_next.edges = '0;
            s_next.pend = 1'b0;
            s_next.sck = CFG.clk_pol;
         end
      end

      // Buffer holds the last byte while the next one shifts in
      if (complete) begin
         s_next.buffer = s_reg.shift;
         s_next.busy = 1'b0;
         s_next.bits = '0;
         s_next.edges = '0;
      end

      // Clears first, so an event in the same cycle wins
      if (BUF_RD) begin
         s_next.bf = 1'b0;
      end
      if (IRQ_CLR) begin
         s_next.irq = 1'b0;
      end
      if (WRITE_COLLISION_FLAG_CLR) begin
         s_next.write_collision_flag = 1'b0;
      end
      if (BCOL_CLR) begin
         s_next.bcol = 1'b0;
      end
      if (complete) begin
         s_next.bf = 1'b1;
         s_next.irq = 1'b1;
      end
      if (wr_coll) begin
         s_next.write_collision_flag = 1'b1;
      end

      // Events may not queue behind a start in progress
      if (CTL2_WR && !i2c_busy) begin
         s_next.ctl2 = CTL2_WDATA;
      end

      if (!i2c_on) begin
         s_next.ist = I2C_IDLE;
         s_next.sda_low = 1'b0;
         s_next.ctl2[SPT_SEN_BIT] = 1'b0;
      end else begin
         case (s_reg.ist)
            I2C_IDLE: begin
               s_next.sda_low = 1'b0;
               if (s_reg.ctl2[SPT_SEN_BIT]) begin
                  if (sda_s && scl_s) begin
                     s_next.ist = I2C_WAIT1;
                     s_next.start_seen = 1'b0;
                  end else if (!sda_s && !scl_s) begin
                     s_next.bcol = 1'b1;
                     s_next.ctl2[SPT_SEN_BIT] = 1'b0;
                  end
               end
            end
            I2C_WAIT1: begin
               // Someone else owns the bus: give it up
               if (!scl_s || (rg_tick && !sda_s)) begin
                  s_next.bcol = 1'b1;
                  s_next.ctl2[SPT_SEN_BIT] = 1'b0;
                  s_next.ist = I2C_IDLE;
               end else if (rg_tick) begin
                  s_next.sda_low = 1'b1;
                  s_next.start_seen = 1'b1;
                  s_next.ist = I2C_HOLD;
               end
            end
            I2C_HOLD: begin
               if (rg_tick) begin
                  s_next.ctl2[SPT_SEN_BIT] = 1'b0;
                  s_next.ist = I2C_LOW;
               end
            end
            I2C_LOW: begin
               // SDA stays low until the port is disabled or leaves I2C mode
               s_next.sda_low = 1'b1;
            end
            default: begin
               s_next.ist = I2C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign BUF_RDATA = s_reg.buffer;
   assign CTL2_Q = s_reg.ctl2;
   assign STATUS.write_collision_flag = s_reg.write_collision_flag;
   assign STATUS.bcol = s_reg.bcol;
   assign STATUS.start_seen = s_reg.start_seen;
   assign STATUS.bf = s_reg.bf;
   assign STATUS.irq = s_reg.irq;
   assign STATUS.busy = xfer_busy;

   // Pin directions from the role, no direction bits needed
   assign SCK_O = s_reg.sck;
   assign SCK_OE = spi_on & CFG.master;
   assign SDO_O = s_reg.serial_data_out;
   assign SDO_OE = spi_on & (CFG.master | ~ss_off);
   assign SDA_O = 1'b0;
   assign SDA_OE = i2c_on & s_reg.sda_low;

   // Helper: leading clock edges of the current master transfer
   logic [3:0] pulses_reg;
   always_ff @(posedge CLK) begin
      if (!RST_B || (wr_go && CFG.master)) begin
         pulses_reg <= '0;
      end else if (m_run && rg_tick && m_lead && s_reg.edges != SPT_EDGE_CNT) begin
         pulses_reg <= pulses_reg + SPT_BIT_STEP;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_start_ok;
      s_reg.ist == I2C_WAIT1 && rg_tick && sda_s && scl_s && i2c_on;
   endsequence

   sequence s_start_held;
      SDA_OE && s_reg.start_seen;
   endsequence

   chk_done_fills_buffer: assert property (
      complete |=> s_reg.bf && s_reg.irq && BUF_RDATA == $past(s_reg.shift))
      else $error("byte completion did not load buffer and flags");
   // A shift edge or a completion in the same cycle moves these on its own
   chk_write_collision_flag_on_write: assert property (
      wr_coll && !(m_run && rg_tick) && !s_edge && !complete
      |=> s_reg.write_collision_flag && $stable(BUF_RDATA) && $stable(s_reg.shift))
      else $error("write during transfer was not refused");
   chk_write_collision_flag_sticky: assert property (
      s_reg.write_collision_flag && !WRITE_COLLISION_FLAG_CLR |=> s_reg.write_collision_flag)
      else $error("collision flag dropped without a clear");
   chk_read_clears_full: assert property (
      BUF_RD && !complete |=> !s_reg.bf)
      else $error("buffer read did not clear full flag");
   chk_eight_pulses: assert property (
      complete && CFG.master |-> pulses_reg == SPT_BIT_CNT)
      else $error("master transfer did not send eight pulses");
   chk_disable_pins: assert property (
      !CFG.enable |-> !SCK_OE && !SDO_OE && !SDA_OE ##1 !STATUS.busy)
      else $error("disabled port still drives pins");
   chk_start_low: assert property (
      s_start_ok |=> s_start_held ##0 s_reg.ist == I2C_HOLD)
      else $error("start did not pull data line low");
   chk_start_ends: assert property (
      s_reg.ist == I2C_HOLD && rg_tick && i2c_on |=> !CTL2_Q[SPT_SEN_BIT] && SDA_OE [*2])
      else $error("second timeout did not finish start");
   chk_bcol_abort: assert property (
      s_reg.ist == I2C_WAIT1 && i2c_on && !scl_s |=> STATUS.bcol && s_reg.ist == I2C_IDLE && !SDA_OE)
      else $error("early clock low did not abort start");
   chk_ctl2_blocked: assert property (
      CTL2_WR && s_reg.ist == I2C_WAIT1 && i2c_on && scl_s && !rg_tick |=> $stable(CTL2_Q))
      else $error("control two write accepted during start");

endmodule

`default_nettype wire

// ===== inc/spt_pkg.sv
// Shared constants and types of the synchronous serial port
package spt_pkg;

   localparam int SPT_RLD_W = 7;
   localparam int SPT_CTL2_W = 5;
   localparam int SPT_SEN_BIT = 0;
   localparam logic [4:0] SPT_EDGE_CNT = 5'h10;
   localparam logic [3:0] SPT_BIT_CNT = 4'h8;
   localparam logic [4:0] SPT_EDGE_STEP = 5'h01;
   localparam logic [3:0] SPT_BIT_STEP = 4'h1;
   // Half period of the master clock, in cycles minus one
   localparam logic [6:0] SPT_HALF_RATE0 = 7'h00;
   localparam logic [6:0] SPT_HALF_RATE1 = 7'h01;
   localparam logic [6:0] SPT_HALF_RATE2 = 7'h07;

   typedef enum logic [1:0] {
      I2C_IDLE,
      I2C_WAIT1,
      I2C_HOLD,
      I2C_LOW
   } spt_i2c_e;

   typedef struct packed {
      logic enable;
      logic master;
      logic clk_pol;
      logic sample_end;
      logic out_on_idle;
      logic [1:0] rate_sel;
      logic ss_en;
      logic i2c_mode;
   } spt_cfg_s;

   typedef struct packed {
      logic write_collision_flag;
      logic bcol;
      logic start_seen;
      logic bf;
      logic irq;
      logic busy;
   } spt_status_s;

   typedef struct packed {
      logic [1:0] sck_sy;
      logic [1:0] sdi_sy;
      logic [1:0] ss_sy;
      logic [1:0] sda_sy;
      logic [1:0] scl_sy;
      logic sck_prev;
      logic [7:0] shift;
      logic [7:0] buffer;
      logic serial_data_out;
      logic sck;
      logic busy;
      logic pend;
      logic [4:0] edges;
      logic [3:0] bits;
      logic bf;
      logic irq;
      logic write_collision_flag;
      logic bcol;
      logic start_seen;
      logic sda_low;
      logic [SPT_CTL2_W-1:0] ctl2;
      spt_i2c_e ist;
   } spt_state_s;

endpackage

// ===== src/spt_rate_gen.sv
// Reloadable down counter used as the serial rate generator
`timescale 1ns/1ps
`default_nettype none

module spt_rate_gen #(
   parameter int RLD_W = 7
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic run,
   input wire logic [RLD_W-1:0] reload,
   output logic tick
);

   typedef struct packed {
      logic [RLD_W-1:0] count;
   } spt_rg_state_s;

   spt_rg_state_s s_reg;
   spt_rg_state_s s_next;

   if (RLD_W < 1 || RLD_W > 16) begin : g_chk
      $error("rate generator width out of range");
   end

   // Load wins over a tick so a restart never fires early
   assign tick = run & ~load & (s_reg.count == '0);

   always_comb begin
      s_next = s_reg;
      if (load) begin
         s_next.count = reload;
      end else if (run) begin
         if (s_reg.count == '0) begin
            s_next.count = reload;
         end else begin
            s_next.count = s_reg.count - {{(RLD_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   chk_tick_reload: assert property (@(posedge clk) disable iff (!rst_b)
      tick |=> s_reg.count == $past(reload)) else $error("rate generator did not reload");

endmodule

`default_nettype wire

// ===== dv/spt_peer.sv
// Peer slave on the far side of the serial port
`timescale 1ns/1ps
`default_nettype none

module spt_peer (
   input wire logic sck,
   input wire logic pol,
   input wire logic mosi,
   output logic miso,
   output logic [7:0] rx
);
   logic [7:0] tx = 8'h00;
   logic ck;
   // Same idle polarity as the port; ck rises on the leading edge
   assign ck = sck ^ pol;
   // Slave only follows the master clock
   assign miso = tx[7];
   // Sample leading, shift trailing
   always @(posedge ck) rx <= {rx[6:0], mosi};
   // Filler bit flips so a stale bit never looks valid
   always @(negedge ck) tx <= {tx[6:0], ~tx[0]};
   task automatic load(input logic [7:0] b);
      tx = b;
   endtask
endmodule

`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench of the serial port
`timescale 1ns/1ps
`default_nettype none

module tb;
   import spt_pkg::*;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   spt_cfg_s cfg = '0;
   logic buf_wr = 1'b0;
   logic [7:0] buf_wdata = 8'h00;
   logic buf_rd = 1'b0;
   logic [7:0] buf_rdata;
   logic irq_clr = 1'b0;
   logic write_collision_flag_clr = 1'b0;
   logic bcol_clr = 1'b0;
   logic ctl2_wr = 1'b0;
   logic [SPT_CTL2_W-1:0] ctl2_wdata = '0;
   logic [SPT_CTL2_W-1:0] ctl2_q;
   logic [SPT_RLD_W-1:0] rate = 7'h03;
   spt_status_s st;
   logic sck_o, sck_oe, serial_data_in, sdo_o, sdo_oe, sda_o, sda_oe;
   logic sda_drv = 1'b1;
   logic scl_drv = 1'b1;
   logic sda_i, scl_i;
   logic sck_in = 1'b0;
   logic ss_b = 1'b1;
   logic tb_mosi = 1'b0;
   logic [7:0] peer_rx;
   int err_total = 0;
   int checks_done = 0;
   int pulses = 0;
   // Open-drain SDA with pull-up
   assign sda_i = sda_drv & ~sda_oe;
   assign scl_i = scl_drv;

   initial begin
      forever #5 CLK = ~CLK;
   end
   always @(posedge sck_o) pulses++;

   spt_top u_dut (.CLK(CLK), .RST_B(RST_B), .CFG(cfg), .BUF_WR(buf_wr), .BUF_WDATA(buf_wdata),
      .BUF_RD(buf_rd), .BUF_RDATA(buf_rdata), .IRQ_CLR(irq_clr), .WRITE_COLLISION_FLAG_CLR(write_collision_flag_clr),
      .BCOL_CLR(bcol_clr), .CTL2_WR(ctl2_wr), .CTL2_WDATA(ctl2_wdata), .CTL2_Q(ctl2_q),
      .RATE_RELOAD(rate), .STATUS(st), .SCK_I(sck_in), .SCK_O(sck_o), .SCK_OE(sck_oe),
      .SERIAL_DATA_IN(cfg.master ? serial_data_in : tb_mosi), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SS_B(ss_b), .SDA_I(sda_i),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .SCL_I(scl_i));
   spt_peer u_peer (.sck(sck_o), .pol(cfg.clk_pol), .mosi(sdo_o), .miso(serial_data_in), .rx(peer_rx));

   task automatic tick(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_buf(input logic [7:0] d);
      buf_wr = 1'b1;
      buf_wdata = d;
      tick(1);
      buf_wr = 1'b0;
   endtask
   task automatic wr_ctl2(input logic [4:0] d);
      ctl2_wr = 1'b1;
      ctl2_wdata = d;
      tick(1);
      ctl2_wr = 1'b0;
   endtask
   function automatic logic done_cond(input int m);
      case (m)
         0: return st.busy === 1'b0;
         1: return st.start_seen === 1'b1;
         default: return ctl2_q[SPT_SEN_BIT] === 1'b0;
      endcase
   endfunction
   // Bounded wait; a hang ends the run
   task automatic wait_on(input int m);
      int n;
      n = 0;
      while (!done_cond(m) && n < 2000) begin
         tick(1);
         n++;
      end
      if (n >= 2000) begin
         err_total++;
         results();
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One master byte; peer answers with rx_b
   task automatic xfer(input logic [7:0] tx_b, input logic [7:0] rx_b);
      u_peer.load(rx_b);
      pulses = 0;
      wr_buf(tx_b);
      wait_on(0);
      tick(2);
      chk(buf_rdata, rx_b);
      chk(peer_rx, tx_b);
      chk(8'(pulses), 8'h08);
   endtask
   // Bench as master, polarity 0; half period well above the slave's sync latency
   task automatic slv_xfer(input logic [7:0] m_b, input logic [7:0] s_b);
      logic [7:0] got;
      got = 8'h00;
      wr_buf(s_b);
      ss_b = 1'b0;
      tick(4);
      chk(8'(sdo_oe), 8'h01);
      for (int i = 7; i >= 0; i--) begin
         tb_mosi = m_b[i];
         tick(8);
         got[i] = sdo_o;
         sck_in = 1'b1;
         tick(8);
         sck_in = 1'b0;
      end
      tick(8);
      ss_b = 1'b1;
      chk(buf_rdata, m_b);
      chk(got, s_b);
   endtask

   initial begin
      tick(10);
      RST_B = 1'b1;
      tick(2);
      cfg.enable = 1'b1;
      cfg.master = 1'b1;
      cfg.out_on_idle = 1'b1;
      cfg.rate_sel = 2'h2;
      tick(2);
      chk(8'(sck_oe), 8'h01);
      chk(8'(sdo_oe), 8'h01);
      u_peer.load(8'h3C);
      pulses = 0;
      wr_buf(8'hA5);
      tick(1);
      wr_buf(8'h11);
      chk(8'(st.write_collision_flag), 8'h01);
      wait_on(0);
      tick(2);
      chk(buf_rdata, 8'h3C);
      chk(peer_rx, 8'hA5);
      chk(8'(pulses), 8'h08);
      chk(8'(st.bf), 8'h01);
      chk(8'(st.irq), 8'h01);
      chk(8'(st.write_collision_flag), 8'h01);
      // Buffer not read: next byte still lands
      xfer(8'h5A, 8'h96);
      buf_rd = 1'b1;
      tick(1);
      buf_rd = 1'b0;
      tick(1);
      chk(8'(st.bf), 8'h00);
      write_collision_flag_clr = 1'b1;
      irq_clr = 1'b1;
      tick(1);
      write_collision_flag_clr = 1'b0;
      irq_clr = 1'b0;
      tick(1);
      chk(8'(st.write_collision_flag), 8'h00);
      xfer(8'h00, 8'hFF);
      xfer(8'hFF, 8'h01);
      // Idle-high clock, end sampling, reload-based rate
      cfg.clk_pol = 1'b1;
      cfg.sample_end = 1'b1;
      cfg.rate_sel = 2'h3;
      tick(2);
      chk(8'(sck_o), 8'h01);
      xfer(8'hC3, 8'h5A);
      cfg.clk_pol = 1'b0;
      cfg.sample_end = 1'b0;
      cfg.rate_sel = 2'h2;
      $display("test master done");
      cfg.master = 1'b0;
      cfg.ss_en = 1'b1;
      tick(2);
      chk(8'(sck_oe), 8'h00);
      chk(8'(sdo_oe), 8'h00);
      slv_xfer(8'h6B, 8'hD4);
      cfg.master = 1'b1;
      cfg.ss_en = 1'b0;
      $display("test slave done");
      cfg.enable = 1'b0;
      tick(2);
      cfg.enable = 1'b1;
      cfg.i2c_mode = 1'b1;
      tick(2);
      wr_ctl2(5'h01);
      tick(2);
      wr_buf(8'h77);
      chk(8'(st.write_collision_flag), 8'h01);
      chk(8'(sda_oe), 8'h00);
      wr_ctl2(5'h1E);
      chk(8'(ctl2_q), 8'h01);
      wait_on(1);
      tick(1);
      chk(8'(sda_oe), 8'h01);
      chk(8'(sda_o), 8'h00);
      chk(8'(st.start_seen), 8'h01);
      chk(8'(st.bcol), 8'h00);
      wait_on(2);
      tick(3);
      chk(8'(ctl2_q), 8'h00);
      chk(8'(sda_oe), 8'h01);
      chk(buf_rdata, 8'h6B);
      $display("test start done");
      // Disable returns the sequencer to idle
      cfg.enable = 1'b0;
      tick(2);
      cfg.enable = 1'b1;
      sda_drv = 1'b0;
      scl_drv = 1'b0;
      tick(3);
      wr_ctl2(5'h01);
      tick(6);
      chk(8'(st.bcol), 8'h01);
      chk(8'(ctl2_q), 8'h00);
      chk(8'(sda_oe), 8'h00);
      bcol_clr = 1'b1;
      tick(1);
      bcol_clr = 1'b0;
      tick(1);
      chk(8'(st.bcol), 8'h00);
      // Clock line pulled low while waiting for the first timeout
      sda_drv = 1'b1;
      scl_drv = 1'b1;
      tick(3);
      wr_ctl2(5'h01);
      tick(1);
      scl_drv = 1'b0;
      tick(4);
      chk(8'(st.bcol), 8'h01);
      chk(8'(ctl2_q), 8'h00);
      chk(8'(sda_oe), 8'h00);
      scl_drv = 1'b1;
      $display("test collision done");
      cfg.enable = 1'b0;
      cfg.i2c_mode = 1'b0;
      tick(2);
      chk(8'(sck_oe), 8'h00);
      chk(8'(sdo_oe), 8'h00);
      wr_buf(8'h42);
      chk(8'(st.busy), 8'h00);
      $display("test disable done");
      results();
   end
endmodule

`default_nettype wire
